// *** rtl/nvc_nested_vector_irq_ctrl.sv ***
// Our own choices: the APB slave port and the address map.
`include "nvc_defs.svh"

module nvc_nested_vector_irq_ctrl #(
   parameter int PIN_GROUP_W = 8,
   parameter int EXCL_PIN    = 2,
   parameter int STK_D       = 8
) (
   input  wire logic                   REF_CLK_IN,
   input  wire logic                   RESETN_IN,
   input  wire logic                   PSEL_IN,
   input  wire logic                   PENABLE_IN,
   input  wire logic                   PWRITE_IN,
   input  wire logic [11:0]            PADDR_IN,
   input  wire logic [31:0]            PWDATA_IN,
   output logic      [31:0]            PRDATA_OUT,
   output logic                        PREADY_OUT,
   output logic                        PSLVERR_OUT,
   input  wire logic [31:0]            IRQ_IN,
   input  wire logic                   EXT_PIN_IRQ_A_IN,
   input  wire logic                   EXT_PIN_IRQ_B_IN,
   input  wire logic                   EXT_PIN_IRQ_C_IN,
   input  wire logic [PIN_GROUP_W-1:0] PIN_GROUP_IRQ_IN,
   input  wire logic                   NMI_IN,
   input  wire logic                   HARD_FAULT_IN,
   input  wire logic                   SVC_IN,
   input  wire logic                   CORE_ENTRY_DONE_IN,
   input  wire logic                   CORE_EXC_RETURN_IN,
   output logic                        ENTRY_REQ_OUT,
   output logic                        STACK_PUSH_OUT,
   output logic      [31:0]            VECTOR_ADDR_OUT,
   output logic      [5:0]             EXC_NUM_OUT,
   output logic                        HANDLER_MODE_OUT,
   output logic                        UNSTACK_OUT
);

   localparam int SPW = $clog2(STK_D) + 1;

   // APB slave, one access-phase cycle, no wait states
   logic               pready_q;
   logic               pslverr_q;
   logic [31:0]        prdata_q;
   logic [31:0]        rdata_d;
   logic               mapped_d;

   wire setup    = PSEL_IN & ~PENABLE_IN;
   wire acc_done = PSEL_IN & PENABLE_IN & pready_q;
   wire wr       = acc_done & PWRITE_IN;
   wire rd       = acc_done & ~PWRITE_IN;

   wire hit_ctrl   = PADDR_IN == `NVC_OFS_SYST_CTRL;
   wire hit_load   = PADDR_IN == `NVC_OFS_SYST_LOAD;
   wire hit_val    = PADDR_IN == `NVC_OFS_SYST_VAL;
   wire hit_iser   = PADDR_IN == `NVC_OFS_ISER;
   wire hit_icer   = PADDR_IN == `NVC_OFS_ICER;
   wire hit_ispr   = PADDR_IN == `NVC_OFS_ISPR;
   wire hit_icpr   = PADDR_IN == `NVC_OFS_ICPR;
   wire hit_active = PADDR_IN == `NVC_OFS_ACTIVE;
   wire hit_ipr    = (PADDR_IN[11:5] == `NVC_OFS_IPR_BASE >> 5) && (PADDR_IN[1:0] == 2'h0);
   wire hit_syspri = PADDR_IN == `NVC_OFS_SYS_PRI;
   wire hit_swctl  = PADDR_IN == `NVC_OFS_SW_CTRL;
   wire [2:0] ipr_idx = PADDR_IN[4:2];

   wire [31:0] iser_w  = (wr && hit_iser)  ? PWDATA_IN : `NVC_RST_WORD;
   wire [31:0] icer_w  = (wr && hit_icer)  ? PWDATA_IN : `NVC_RST_WORD;
   wire [31:0] ispr_w  = (wr && hit_ispr)  ? PWDATA_IN : `NVC_RST_WORD;
   wire [31:0] icpr_w  = (wr && hit_icpr)  ? PWDATA_IN : `NVC_RST_WORD;
   wire [31:0] swctl_w = (wr && hit_swctl) ? PWDATA_IN : `NVC_RST_WORD;

   // Interrupt state
   logic [31:0]        irq_en_q;
   logic [31:0]        irq_pend_q;
   nvc_pkg::nvc_pri_t  prio_q [32];
   nvc_pkg::nvc_pri_t  sys_pri_q [3];
   logic               nmi_pend_q;
   logic               hf_pend_q;
   logic               svc_pend_q;
   logic               psv_pend_q;
   logic               st_pend_q;
   logic [47:0]        act_q;

   // System tick
   logic [23:0]        st_val_q;
   logic [23:0]        st_load_q;
   logic               st_en_q;
   logic               st_tickint_q;
   logic               st_cflag_q;

   // Exception sequencing
   nvc_pkg::nvc_state_t state_q;
   nvc_pkg::nvc_exc_t  tgt_q;
   nvc_pkg::nvc_rank_t tgt_rank_q;
   nvc_pkg::nvc_exc_t  stk_num_q [STK_D];
   nvc_pkg::nvc_rank_t stk_rank_q [STK_D];
   logic [SPW-1:0]     sp_q;
   logic               entry_q;
   logic               push_q;
   logic [31:0]        vec_q;
   nvc_pkg::nvc_exc_t  exc_num_q;
   logic               hmode_q;
   logic               unstack_q;

   // Source wiring of the dedicated lines
   logic [31:0]        irq_src;
   logic [PIN_GROUP_W-1:0] group_mask;
   always_comb begin
      group_mask           = '1;
      group_mask[EXCL_PIN] = 1'b0;
      irq_src              = IRQ_IN;
      irq_src[`NVC_IRQ_EXT_A] = EXT_PIN_IRQ_A_IN;
      irq_src[`NVC_IRQ_EXT_B] = EXT_PIN_IRQ_B_IN;
      irq_src[`NVC_IRQ_EXT_C] = EXT_PIN_IRQ_C_IN;
      irq_src[`NVC_IRQ_PIN_GROUP] = |(PIN_GROUP_IRQ_IN & group_mask);
   end

   // Candidate set and urgency ranks, indexed by exception number
   logic [47:0]        cand;
   nvc_pkg::nvc_rank_t rank_v [48];
   always_comb begin
      cand = 48'h0;
      cand[`NVC_EXC_NMI]        = nmi_pend_q;
      cand[`NVC_EXC_HARD_FAULT] = hf_pend_q;
      cand[`NVC_EXC_SVC]        = svc_pend_q;
      cand[`NVC_EXC_PENDABLE_SERVICE_EXCEPTION]     = psv_pend_q;
      cand[`NVC_EXC_SYSTEM_TICK_EXCEPTION]    = st_pend_q;
      cand[`NVC_EXC_LAST:`NVC_EXC_IRQ_BASE] = irq_pend_q & irq_en_q;
      for (int i = 0; i < 48; i++) begin
         rank_v[i] = `NVC_RANK_THREAD;
      end
      rank_v[`NVC_EXC_NMI]        = `NVC_RANK_NMI;
      rank_v[`NVC_EXC_HARD_FAULT] = `NVC_RANK_HARD_FAULT;
      rank_v[`NVC_EXC_SVC]        = `NVC_RANK_CFG_BASE + {1'b0, sys_pri_q[0]};
      rank_v[`NVC_EXC_PENDABLE_SERVICE_EXCEPTION]     = `NVC_RANK_CFG_BASE + {1'b0, sys_pri_q[1]};
      rank_v[`NVC_EXC_SYSTEM_TICK_EXCEPTION]    = `NVC_RANK_CFG_BASE + {1'b0, sys_pri_q[2]};
      for (int k = 0; k < 32; k++) begin
         rank_v[`NVC_EXC_IRQ_BASE + k] = `NVC_RANK_CFG_BASE + {1'b0, prio_q[k]};
      end
   end

   // Most urgent candidate; ascending scan with strict compare keeps the lowest number on ties
   nvc_pkg::nvc_exc_t  best_num;
   nvc_pkg::nvc_rank_t best_rank;
   always_comb begin
      best_num  = 6'h00;
      best_rank = `NVC_RANK_THREAD;
      for (int i = 0; i < 48; i++) begin
         if (cand[i] && (rank_v[i] < best_rank)) begin
            best_num  = 6'(i);
            best_rank = rank_v[i];
         end
      end
   end

   wire [SPW-1:0]      sp_m1     = sp_q - SPW'(1);
   wire [SPW-1:0]      sp_m2     = sp_q - SPW'(2);
   wire nvc_pkg::nvc_rank_t cur_rank  = (sp_q == '0) ? `NVC_RANK_THREAD : stk_rank_q[sp_m1[SPW-2:0]];
   wire nvc_pkg::nvc_rank_t next_rank = (sp_q < SPW'(2)) ? `NVC_RANK_THREAD : stk_rank_q[sp_m2[SPW-2:0]];
   wire nvc_pkg::nvc_exc_t  top_num   = stk_num_q[sp_m1[SPW-2:0]];
   wire nvc_pkg::nvc_exc_t  next_num  = stk_num_q[sp_m2[SPW-2:0]];

   wire in_run     = state_q == nvc_pkg::ST_RUN;
   wire in_entry   = state_q == nvc_pkg::ST_ENTRY;
   wire do_ret     = in_run && CORE_EXC_RETURN_IN && (sp_q != '0);
   wire do_chain   = do_ret && (best_rank < next_rank);
   wire do_preempt = in_run && !do_ret && (best_rank < cur_rank);
   wire do_late    = in_entry && (best_rank < tgt_rank_q);
   wire do_accept  = in_entry && CORE_ENTRY_DONE_IN;
   wire [31:0] best_vec = `NVC_VEC_BASE | {24'h0, best_num, 2'b00};

   wire [47:0] act_set = do_accept ? (48'h1 << tgt_q) : 48'h0;
   wire [47:0] act_clr = do_ret ? (48'h1 << top_num) : 48'h0;

   // Exception entry and return sequencer
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         state_q    <= nvc_pkg::ST_RUN;
         tgt_q      <= 6'h00;
         tgt_rank_q <= `NVC_RANK_THREAD;
         sp_q       <= '0;
         entry_q    <= 1'b0;
         push_q     <= 1'b0;
         vec_q      <= `NVC_VEC_BASE;
         exc_num_q  <= 6'h00;
         hmode_q    <= 1'b0;
         unstack_q  <= 1'b0;
      end else begin
         unstack_q <= 1'b0;
         if (do_preempt || do_chain || do_late) begin
            state_q    <= nvc_pkg::ST_ENTRY;
            tgt_q      <= best_num;
            tgt_rank_q <= best_rank;
            vec_q      <= best_vec;
            entry_q    <= 1'b1;
         end
         if (do_preempt) begin
            push_q <= 1'b1;
         end
         if (do_chain) begin
            push_q <= 1'b0;
            sp_q   <= sp_m1;
         end
         if (do_ret && !do_chain) begin
            unstack_q <= 1'b1;
            sp_q      <= sp_m1;
            exc_num_q <= (sp_q < SPW'(2)) ? 6'h00 : next_num;
            hmode_q   <= sp_q >= SPW'(2);
         end
         if (do_accept) begin
            state_q   <= nvc_pkg::ST_RUN;
            entry_q   <= 1'b0;
            push_q    <= 1'b0;
            sp_q      <= sp_q + SPW'(1);
            exc_num_q <= tgt_q;
            hmode_q   <= 1'b1;
         end
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (do_accept) begin
         stk_num_q[sp_q[SPW-2:0]]  <= tgt_q;
         stk_rank_q[sp_q[SPW-2:0]] <= tgt_rank_q;
      end
   end

   // Enable, pending and active vectors; a new event wins over a clear in the same cycle
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         irq_en_q   <= `NVC_RST_WORD;
         irq_pend_q <= `NVC_RST_WORD;
         act_q      <= 48'h0;
         nmi_pend_q <= 1'b0;
         hf_pend_q  <= 1'b0;
         svc_pend_q <= 1'b0;
         psv_pend_q <= 1'b0;
      end else begin
         irq_en_q   <= (irq_en_q | iser_w) & ~icer_w;
         irq_pend_q <= (irq_pend_q & ~icpr_w & ~act_set[`NVC_EXC_LAST:`NVC_EXC_IRQ_BASE])
                       | irq_src | ispr_w;
         act_q      <= (act_q & ~act_clr) | act_set;
         nmi_pend_q <= (nmi_pend_q & ~act_set[`NVC_EXC_NMI]) | NMI_IN;
         hf_pend_q  <= (hf_pend_q & ~act_set[`NVC_EXC_HARD_FAULT]) | HARD_FAULT_IN;
         svc_pend_q <= (svc_pend_q & ~act_set[`NVC_EXC_SVC]) | SVC_IN;
         psv_pend_q <= (psv_pend_q & ~act_set[`NVC_EXC_PENDABLE_SERVICE_EXCEPTION] & ~swctl_w[`NVC_SW_CLR_PSV_BIT])
                       | swctl_w[`NVC_SW_SET_PSV_BIT];
      end
   end

   // Priority fields keep only their top two bits
   genvar gk;
   generate
      for (gk = 0; gk < 32; gk++) begin : g_prio
         always_ff @(posedge REF_CLK_IN) begin
            if (!RESETN_IN) begin
               prio_q[gk] <= `NVC_RST_PRI;
            end else if (wr && hit_ipr && (ipr_idx == 3'(gk / 4))) begin
               prio_q[gk] <= PWDATA_IN[(gk % 4) * `NVC_PRI_FIELD_W + `NVC_PRI_MSB -: 2];
            end
         end
      end
      for (gk = 0; gk < 3; gk++) begin : g_sys_prio
         always_ff @(posedge REF_CLK_IN) begin
            if (!RESETN_IN) begin
               sys_pri_q[gk] <= `NVC_RST_PRI;
            end else if (wr && hit_syspri) begin
               sys_pri_q[gk] <= PWDATA_IN[gk * `NVC_PRI_FIELD_W + `NVC_PRI_MSB -: 2];
            end
         end
      end
   endgenerate

   // System tick counter
   wire st_hit_zero = st_en_q && (st_val_q == 24'h000001);
   wire st_ctrl_rd  = rd && hit_ctrl;
   wire st_val_wr   = wr && hit_val;

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         st_val_q     <= 24'h000000;
         st_load_q    <= 24'h000000;
         st_en_q      <= 1'b0;
         st_tickint_q <= 1'b0;
         st_cflag_q   <= 1'b0;
         st_pend_q    <= 1'b0;
      end else begin
         if (wr && hit_ctrl) begin
            st_en_q      <= PWDATA_IN[`NVC_ST_EN_BIT];
            st_tickint_q <= PWDATA_IN[`NVC_ST_TICKINT_BIT];
         end
         if (wr && hit_load) begin
            st_load_q <= PWDATA_IN[23:0];
         end
         // A software write zeroes the count and clears the count flag unless the count also hits zero in that cycle; it never raises the tick exception
         if (st_val_wr) begin
            st_val_q <= 24'h000000;
         end else if (st_en_q) begin
            st_val_q <= (st_val_q == 24'h000000) ? st_load_q : st_val_q - 24'h000001;
         end
         st_cflag_q <= (st_cflag_q & ~st_ctrl_rd & ~st_val_wr) | st_hit_zero;
         st_pend_q  <= (st_pend_q & ~act_set[`NVC_EXC_SYSTEM_TICK_EXCEPTION] & ~swctl_w[`NVC_SW_CLR_ST_BIT])
                       | (st_hit_zero & st_tickint_q & ~st_val_wr) | swctl_w[`NVC_SW_SET_ST_BIT];
      end
   end

   // Read data selection
   always_comb begin
      rdata_d  = `NVC_RST_WORD;
      mapped_d = 1'b1;
      if (hit_ctrl) begin
         rdata_d[`NVC_ST_EN_BIT]      = st_en_q;
         rdata_d[`NVC_ST_TICKINT_BIT] = st_tickint_q;
         rdata_d[`NVC_ST_CLKSRC_BIT]  = 1'b1;
         rdata_d[`NVC_ST_CFLAG_BIT]   = st_cflag_q;
      end else if (hit_load) begin
         rdata_d[23:0] = st_load_q;
      end else if (hit_val) begin
         rdata_d[23:0] = st_val_q;
      end else if (hit_iser || hit_icer) begin
         rdata_d = irq_en_q;
      end else if (hit_ispr || hit_icpr) begin
         rdata_d = irq_pend_q;
      end else if (hit_active) begin
         rdata_d = act_q[`NVC_EXC_LAST:`NVC_EXC_IRQ_BASE];
      end else if (hit_ipr) begin
         for (int j = 0; j < 4; j++) begin
            rdata_d[j * `NVC_PRI_FIELD_W + `NVC_PRI_MSB -: 2] = prio_q[{ipr_idx, 2'(j)}];
         end
      end else if (hit_syspri) begin
         for (int j = 0; j < 3; j++) begin
            rdata_d[j * `NVC_PRI_FIELD_W + `NVC_PRI_MSB -: 2] = sys_pri_q[j];
         end
      end else if (hit_swctl) begin
         rdata_d[5:0]                  = exc_num_q;
         rdata_d[`NVC_SW_PSV_PEND_BIT] = psv_pend_q;
         rdata_d[`NVC_SW_ST_PEND_BIT]  = st_pend_q;
         rdata_d[`NVC_SW_SVC_PEND_BIT] = svc_pend_q;
         rdata_d[`NVC_SW_HMODE_BIT]    = hmode_q;
      end else begin
         mapped_d = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= `NVC_RST_WORD;
      end else begin
         pready_q <= setup;
         if (setup) begin
            pslverr_q <= ~mapped_d;
            prdata_q  <= PWRITE_IN ? `NVC_RST_WORD : rdata_d;
         end
      end
   end

   assign PRDATA_OUT       = prdata_q;
   assign PREADY_OUT       = pready_q;
   assign PSLVERR_OUT      = pslverr_q;
   assign ENTRY_REQ_OUT    = entry_q;
   assign STACK_PUSH_OUT   = push_q;
   assign VECTOR_ADDR_OUT  = vec_q;
   assign EXC_NUM_OUT      = exc_num_q;
   assign HANDLER_MODE_OUT = hmode_q;
   assign UNSTACK_OUT      = unstack_q;

endmodule // nvc_nested_vector_irq_ctrl

// *** shared/nvc_defs.svh ***
`ifndef NVC_DEFS_SVH
`define NVC_DEFS_SVH

// Register byte offsets on the APB window
`define NVC_OFS_SYST_CTRL   12'h010
`define NVC_OFS_SYST_LOAD   12'h014
`define NVC_OFS_SYST_VAL    12'h018
`define NVC_OFS_ISER        12'h100
`define NVC_OFS_ICER        12'h180
`define NVC_OFS_ISPR        12'h200
`define NVC_OFS_ICPR        12'h280
`define NVC_OFS_ACTIVE      12'h300
`define NVC_OFS_IPR_BASE    12'h400
`define NVC_OFS_SYS_PRI     12'h420
`define NVC_OFS_SW_CTRL     12'h430

// Reset values
`define NVC_RST_WORD        32'h0000_0000
`define NVC_RST_PRI         2'h0
`define NVC_VEC_BASE        32'h0000_0000

// Field positions
`define NVC_PRI_FIELD_W     8
`define NVC_PRI_MSB         7
`define NVC_ST_EN_BIT       0
`define NVC_ST_TICKINT_BIT  1
`define NVC_ST_CLKSRC_BIT   2
`define NVC_ST_CFLAG_BIT    16
`define NVC_SW_SET_PSV_BIT  0
`define NVC_SW_CLR_PSV_BIT  1
`define NVC_SW_SET_ST_BIT   2
`define NVC_SW_CLR_ST_BIT   3
`define NVC_SW_PSV_PEND_BIT 8
`define NVC_SW_ST_PEND_BIT  9
`define NVC_SW_SVC_PEND_BIT 10
`define NVC_SW_HMODE_BIT    16

// Dedicated interrupt bit positions
`define NVC_IRQ_PIN_GROUP   18
`define NVC_IRQ_EXT_A       24
`define NVC_IRQ_EXT_B       25
`define NVC_IRQ_EXT_C       26

// Exception numbers
`define NVC_EXC_NMI         6'h02
`define NVC_EXC_HARD_FAULT  6'h03
`define NVC_EXC_SVC         6'h0B
`define NVC_EXC_PENDABLE_SERVICE_EXCEPTION      6'h0E
`define NVC_EXC_SYSTEM_TICK_EXCEPTION     6'h0F
`define NVC_EXC_IRQ_BASE    16
`define NVC_EXC_LAST        47

// Internal urgency ranks, lower is more urgent
`define NVC_RANK_NMI        3'h1
`define NVC_RANK_HARD_FAULT 3'h2
`define NVC_RANK_CFG_BASE   3'h3
`define NVC_RANK_THREAD     3'h7

`endif

// *** shared/nvc_pkg.sv ***
package nvc_pkg;
   typedef enum logic {ST_RUN, ST_ENTRY} nvc_state_t;
   typedef logic [5:0] nvc_exc_t;
   typedef logic [2:0] nvc_rank_t;
   typedef logic [1:0] nvc_pri_t;
endpackage

// *** sim/nvc_core_model.sv ***
module nvc_core_model (
   input  wire logic ref_clk_in,
   input  wire logic resetn_in,
   input  wire logic entry_req_in,
   input  var  int   delay_in,
   input  wire logic ret_go_in,
   output logic      entry_done_out,
   output logic      exc_return_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q;
   // Stacking takes delay_in cycles; a slow core widens the window for late arrivals
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         cnt_q <= 0;
         entry_done_out <= 1'h0;
         exc_return_out <= 1'h0;
      end else begin
         exc_return_out <= ret_go_in;
         if (entry_done_out) begin
            entry_done_out <= 1'h0;
            cnt_q <= 0;
         end else if (entry_req_in) begin
            cnt_q <= cnt_q + 1;
            entry_done_out <= (cnt_q + 1 >= delay_in);
         end
      end
   end
endmodule // nvc_core_model

// *** sim/nvc_irq_ctrl_chk.sv ***
module nvc_irq_ctrl_chk (
   input wire logic        REF_CLK_IN,
   input wire logic        RESETN_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PREADY_OUT,
   input wire logic        CORE_ENTRY_DONE_IN,
   input wire logic        CORE_EXC_RETURN_IN,
   input wire logic        ENTRY_REQ_OUT,
   input wire logic        STACK_PUSH_OUT,
   input wire logic [31:0] VECTOR_ADDR_OUT,
   input wire logic [5:0]  EXC_NUM_OUT,
   input wire logic        HANDLER_MODE_OUT,
   input wire logic        UNSTACK_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] vec_num;
   assign vec_num = VECTOR_ADDR_OUT[7:2];
   default clocking dc @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);
   chk_apb_ready: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT ##1 !PREADY_OUT)
      else $error("ready does not follow setup for exactly one cycle");
   chk_vec_range: assert property ($rose(ENTRY_REQ_OUT) |->
      VECTOR_ADDR_OUT[31:8] == 24'h0 && VECTOR_ADDR_OUT[1:0] == 2'h0 &&
      !(vec_num inside {[6'h0:6'h1], [6'h4:6'hA], 6'hC, 6'hD, [6'h30:6'h3F]}))
      else $error("entry vector address outside the table");
   chk_entry_done: assert property (ENTRY_REQ_OUT && CORE_ENTRY_DONE_IN |=>
      !ENTRY_REQ_OUT && HANDLER_MODE_OUT && EXC_NUM_OUT == $past(vec_num))
      else $error("handler started is not the fetched vector");
   chk_late_hold: assert property (ENTRY_REQ_OUT && !CORE_ENTRY_DONE_IN |=>
      ENTRY_REQ_OUT && $stable(STACK_PUSH_OUT))
      else $error("entry dropped or push changed before the core finished");
   chk_fresh_push: assert property ($rose(ENTRY_REQ_OUT) && !$past(CORE_EXC_RETURN_IN) |-> STACK_PUSH_OUT)
      else $error("entry from running code without a stack push");
   chk_tail_nopush: assert property ($rose(ENTRY_REQ_OUT) && $past(CORE_EXC_RETURN_IN) |->
      !STACK_PUSH_OUT && !UNSTACK_OUT)
      else $error("tail chain unstacks or pushes");
   chk_mode_num: assert property (HANDLER_MODE_OUT == (EXC_NUM_OUT != 6'h00))
      else $error("handler mode disagrees with running exception number");
   chk_unstack_why: assert property (UNSTACK_OUT |-> $past(CORE_EXC_RETURN_IN) && !ENTRY_REQ_OUT ##1 !UNSTACK_OUT)
      else $error("unstack without a return or longer than one cycle");
   cov_tail: cover property ($rose(ENTRY_REQ_OUT) && !STACK_PUSH_OUT);
   cov_late: cover property (ENTRY_REQ_OUT && $past(ENTRY_REQ_OUT) && $changed(VECTOR_ADDR_OUT));
   cov_unstack: cover property (UNSTACK_OUT);
endmodule // nvc_irq_ctrl_chk

bind nvc_nested_vector_irq_ctrl nvc_irq_ctrl_chk u_chk (
   .REF_CLK_IN, .RESETN_IN, .PSEL_IN, .PENABLE_IN, .PREADY_OUT, .CORE_ENTRY_DONE_IN, .CORE_EXC_RETURN_IN,
   .ENTRY_REQ_OUT, .STACK_PUSH_OUT, .VECTOR_ADDR_OUT, .EXC_NUM_OUT, .HANDLER_MODE_OUT, .UNSTACK_OUT
);

// *** sim/tb_nested_vectored_irq_controller.sv ***
`include "nvc_defs.svh"
module tb_nested_vectored_irq_controller;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] irq = 32'h0;
   logic [2:0]  ext = 3'h0;
   logic [7:0]  pins = 8'h00;
   logic [2:0]  sys = 3'h0;
   logic        ret_go = 1'h0;
   int          dly = 3;
   logic [31:0] prdata, vec;
   logic        pready, pslverr, done, ret, entry, push, hmode, unstack;
   logic [5:0]  exc;
   int          n_fail = 0;
   int          checks = 0;
   int          i;
   always #10 clk = ~clk;
   nvc_nested_vector_irq_ctrl uut (
      .REF_CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .IRQ_IN(irq), .EXT_PIN_IRQ_A_IN(ext[0]), .EXT_PIN_IRQ_B_IN(ext[1]), .EXT_PIN_IRQ_C_IN(ext[2]),
      .PIN_GROUP_IRQ_IN(pins), .NMI_IN(sys[0]), .HARD_FAULT_IN(sys[1]), .SVC_IN(sys[2]),
      .CORE_ENTRY_DONE_IN(done), .CORE_EXC_RETURN_IN(ret), .ENTRY_REQ_OUT(entry), .STACK_PUSH_OUT(push),
      .VECTOR_ADDR_OUT(vec), .EXC_NUM_OUT(exc), .HANDLER_MODE_OUT(hmode), .UNSTACK_OUT(unstack)
   );
   nvc_core_model core (
      .ref_clk_in(clk), .resetn_in(rst_n), .entry_req_in(entry), .delay_in(dly), .ret_go_in(ret_go),
      .entry_done_out(done), .exc_return_out(ret)
   );
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      n = 0;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      // A slave that never answers counts against the run instead of passing silently
      if (pready !== 1'h1) n_fail++;
      r = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'h1, a, d, r);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'h0, a, 32'h0, r);
      chk(r, e);
   endtask
   task automatic pulse(input logic [2:0] v);
      sys <= v;
      @(posedge clk);
      sys <= 3'h0;
   endtask
   // A bare return leaves the next edge free so a tail chain entry is not missed
   task automatic ret_h(input int w);
      ret_go <= 1'h1;
      @(posedge clk);
      ret_go <= 1'h0;
      repeat (w) @(posedge clk);
   endtask
   task automatic take(input logic [5:0] num, input logic p);
      int n;
      n = 0;
      while (entry !== 1'h1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (entry !== 1'h1) n_fail++;
      chk(vec, {24'h0, num, 2'h0});
      chk(32'(push), 32'(p));
      while (!(hmode === 1'h1 && entry === 1'h0) && n < 100) begin
         @(posedge clk);
         n++;
      end
      if (hmode !== 1'h1) n_fail++;
      chk(32'(exc), 32'(num));
   endtask
   task automatic end_sim;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      chk(vec, 32'h0);
      for (i = 0; i < 8; i++) begin
         rc(`NVC_OFS_IPR_BASE + 12'(4 * i), 32'h0);
      end
      rc(`NVC_OFS_ISER, 32'h0);
      rc(`NVC_OFS_ISPR, 32'h0);
      rc(12'hFFC, 32'h0);
      chk(32'(pslverr), 32'h1);
      $display("test reset values done");
      wr(`NVC_OFS_ISER, 32'h0000_00F0);
      wr(`NVC_OFS_ISER, 32'h0);
      wr(`NVC_OFS_ICER, 32'h0000_0030);
      rc(`NVC_OFS_ICER, 32'h0000_00C0);
      rc(`NVC_OFS_ISER, 32'h0000_00C0);
      wr(`NVC_OFS_ICER, 32'hFFFF_FFFF);
      wr(`NVC_OFS_IPR_BASE + 12'h4, 32'hFFFF_FFFF);
      rc(`NVC_OFS_IPR_BASE + 12'h4, 32'hC0C0_C0C0);
      wr(`NVC_OFS_IPR_BASE + 12'h4, 32'h0000_7F80);
      rc(`NVC_OFS_IPR_BASE + 12'h4, 32'h0000_4080);
      wr(`NVC_OFS_IPR_BASE + 12'h4, 32'h0);
      $display("test enable and priority fields done");
      irq <= 32'h0704_0000;
      pins <= 8'h04;
      rc(`NVC_OFS_ISPR, 32'h0);
      pins <= 8'h01;
      rc(`NVC_OFS_ISPR, 32'h0004_0000);
      for (i = 0; i < 3; i++) begin
         ext <= 3'((2 << i) - 1);
         rc(`NVC_OFS_ISPR, 32'h0004_0000 | (32'((2 << i) - 1) << 24));
      end
      wr(`NVC_OFS_ISPR, 32'h0000_0008);
      rc(`NVC_OFS_ISPR, 32'h0704_0008);
      chk(32'(entry), 32'h0);
      irq <= 32'h0;
      ext <= 3'h0;
      pins <= 8'h00;
      wr(`NVC_OFS_ICPR, 32'hFFFF_FFFF);
      rc(`NVC_OFS_ISPR, 32'h0);
      $display("test pin lines and pending done");
      wr(`NVC_OFS_ISER, 32'h0000_0020);
      irq[5] <= 1'h1;
      take(6'h15, 1'h1);
      irq[5] <= 1'h0;
      wr(`NVC_OFS_ICER, 32'h0000_0020);
      rc(`NVC_OFS_ACTIVE, 32'h0000_0020);
      wr(`NVC_OFS_ICPR, 32'h0000_0020);
      rc(`NVC_OFS_ACTIVE, 32'h0000_0020);
      chk(32'(exc), 32'h15);
      ret_h(4);
      chk(32'(hmode), 32'h0);
      $display("test single entry done");
      wr(`NVC_OFS_IPR_BASE, 32'h4040_8000);
      wr(`NVC_OFS_ISER, 32'h0000_005F);
      wr(`NVC_OFS_ISPR, 32'h0000_0004);
      take(6'h12, 1'h1);
      wr(`NVC_OFS_ISPR, 32'h0000_000A);
      repeat (6) @(posedge clk);
      chk(32'(entry), 32'h0);
      wr(`NVC_OFS_ISPR, 32'h0000_0001);
      take(6'h10, 1'h1);
      ret_h(4);
      chk(32'(exc), 32'h12);
      ret_h(0);
      take(6'h13, 1'h0);
      ret_h(0);
      take(6'h11, 1'h0);
      ret_h(4);
      wr(`NVC_OFS_ISPR, 32'h0000_0050);
      take(6'h14, 1'h1);
      ret_h(0);
      take(6'h16, 1'h0);
      ret_h(4);
      $display("test nesting and tail chain done");
      pulse(3'h4);
      take(`NVC_EXC_SVC, 1'h1);
      ret_h(4);
      wr(`NVC_OFS_SW_CTRL, 32'h0000_0001);
      take(`NVC_EXC_PENDABLE_SERVICE_EXCEPTION, 1'h1);
      ret_h(4);
      wr(`NVC_OFS_SW_CTRL, 32'h0000_0004);
      take(`NVC_EXC_SYSTEM_TICK_EXCEPTION, 1'h1);
      ret_h(4);
      wr(`NVC_OFS_SYST_VAL, 32'h0);
      wr(`NVC_OFS_SYST_LOAD, 32'h0);
      wr(`NVC_OFS_SYST_CTRL, 32'h0000_0003);
      wr(`NVC_OFS_SYST_VAL, 32'h0);
      rc(`NVC_OFS_SW_CTRL, 32'h0);
      wr(`NVC_OFS_SYST_CTRL, 32'h0);
      dly = 10;
      wr(`NVC_OFS_ISPR, 32'h0000_0001);
      i = 0;
      while (entry !== 1'h1 && i < 20) begin
         @(posedge clk);
         i++;
      end
      chk(32'(entry), 32'h1);
      pulse(3'h1);
      repeat (2) @(posedge clk);
      take(`NVC_EXC_NMI, 1'h1);
      dly = 3;
      ret_h(0);
      take(6'h10, 1'h0);
      pulse(3'h2);
      take(`NVC_EXC_HARD_FAULT, 1'h1);
      ret_h(4);
      chk(32'(exc), 32'h10);
      ret_h(4);
      chk(32'(exc), 32'h0);
      $display("test system exceptions and late arrival done");
      end_sim();
   end
endmodule // tb_nested_vectored_irq_controller
